/* hdl/ssli_map.svh */
// Offsets-free constant map: timing counts and codes of the indicator
`ifndef SSLI_MAP_SVH
`define SSLI_MAP_SVH

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define SSLI_CLK_NS 100
`define SSLI_HALF_MS 500
`define SSLI_HALF_CYC ((`SSLI_HALF_MS * 1000000) / `SSLI_CLK_NS)
`define SSLI_PAUSE_MS 2000
`define SSLI_PAUSE_TICKS (`SSLI_PAUSE_MS / `SSLI_HALF_MS)
`define SSLI_CNT_W 23

// ------------------------------------------------------------
// Counts
// ------------------------------------------------------------
`define SSLI_BEEP_ROUNDS 3'h5
`define SSLI_S4_BLINKS 3'h4
`define SSLI_ERR_MIN 4'h2
`define SSLI_ERR_MAX 4'hb

`endif

/* hdl/ssli_pkg.sv */
// Types shared by the status indicator modules
package ssli_pkg;

    typedef enum logic [2:0]
    {
        SSLI_PWR_S0 = 3'b000,
        SSLI_PWR_S1 = 3'b001,
        SSLI_PWR_S3 = 3'b011,
        SSLI_PWR_S4 = 3'b100,
        SSLI_PWR_S5 = 3'b101
    } ssli_pwr_t;

    typedef enum logic [1:0]
    {
        SSLI_ST_IDLE = 2'b00,
        SSLI_ST_ON = 2'b01,
        SSLI_ST_OFF = 2'b10,
        SSLI_ST_PAUSE = 2'b11
    } ssli_state_t;

endpackage

/* hdl/ssli_tick_if.sv */
// Interface carrying the half-second tick between divider and sequencer
`timescale 1ns/1ns
interface ssli_tick_if;
    logic restart;
    logic tick;
    modport gen (input restart, output tick);
    modport user (output restart, input tick);
endinterface

/* hdl/ssli_tick_gen.sv */
// Half-second tick divider with phase restart
`timescale 1ns/1ns
`include "ssli_map.svh"
module ssli_tick_gen #(
    parameter int unsigned HALF_CYC = `SSLI_HALF_CYC
)(
    input wire logic i_clk,
    input wire logic i_rst_n,
    ssli_tick_if.gen tk
);
    logic [`SSLI_CNT_W-1:0] cnt_reg;
    logic [`SSLI_CNT_W-1:0] cnt_next;
    logic at_end;

    assign at_end = (cnt_reg == `SSLI_CNT_W'(HALF_CYC - 1));
    assign tk.tick = at_end && !tk.restart;

    always_comb
    begin
        cnt_next = cnt_reg + `SSLI_CNT_W'(1);
        if (tk.restart || at_end)
        begin
            cnt_next = '0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cnt_reg <= '0;
        end
        else
        begin
            cnt_reg <= cnt_next;
        end
    end

    // Restart must give a full period before the next tick
    chk_tick_after_restart: assert property ( // [R13]
        @(posedge i_clk) disable iff (!i_rst_n)
        tk.restart |=> !tk.tick)
        else $error("tick right after restart");

endmodule // ssli_tick_gen

/* hdl/ssli_top.sv */
// Power LED and speaker status sequencer
// Summary of operation
// (R1) Working state: steady green, no beeps; soft off: LED dark.
// (R2) Standby and suspend to RAM: green blinks at half a hertz, silent.
// (R3) Suspend to disk: dark, or four half-hertz green blinks if enabled.
// (R4) Thermal shutdown: two red blinks at 1 Hz, two beeps per burst.
// (R5) Processor missing: three blinks and beeps; supply overload: four.
// (R6) Memory error before video: five; video error: six, at 1 Hz.
// (R7) Board failure before video: seven; bad firmware checksum: eight.
// (R8) Boot failure after power on: nine red blinks and nine beeps.
// (R9) Bad option card: ten; unsupported enabled feature: eleven.
// (R10) Each burst is followed by two seconds pause, then repeats.
// (R11) Only the first five bursts beep; later bursts blink silently.
// (R12) Beeps go to the speaker output in step with red blinks.
// (R13) Red blinks have equal on/off halves; errors override green.
`timescale 1ns/1ns
`include "ssli_map.svh"
module ssli_top #(
    parameter int unsigned HALF_CYC = `SSLI_HALF_CYC
)(
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire ssli_pkg::ssli_pwr_t i_pwr_state,
    input wire logic [3:0] i_err_code,
    input wire logic i_sleep_blink_en,
    output logic o_led_green,
    output logic o_led_red,
    output logic o_beep
);
    import ssli_pkg::*;

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta_reg, rst_n_reg;

    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // Tick divider
    // ------------------------------------------------------------
    ssli_tick_if tk();

    ssli_tick_gen #(.HALF_CYC(HALF_CYC)) u_tick (
        .i_clk(i_sys_clk),
        .i_rst_n(rst_n_reg),
        .tk(tk)
    );

    // Blink count of an error code; zero means no error shown
    function automatic logic [3:0] err_len(input logic [3:0] code);
        return (code >= `SSLI_ERR_MIN && code <= `SSLI_ERR_MAX) ?
            code : 4'h0; // [R4] [R5] [R6] [R7] [R8] [R9]
    endfunction

    // ------------------------------------------------------------
    // Error burst sequencer
    // ------------------------------------------------------------
    ssli_state_t state_reg, state_next;
    logic [3:0] code_reg, code_next;
    logic [3:0] blk_reg, blk_next;
    logic [2:0] pause_reg, pause_next;
    logic [2:0] round_reg, round_next;
    logic err_valid, restart;
    assign err_valid = (err_len(i_err_code) != 4'h0);
    assign restart = err_valid &&
        (state_reg == SSLI_ST_IDLE || i_err_code != code_reg);
    assign tk.restart = restart;

    always_comb
    begin
        state_next = state_reg;
        code_next = code_reg;
        blk_next = blk_reg;
        pause_next = pause_reg;
        round_next = round_reg;
        if (!err_valid)
        begin
            state_next = SSLI_ST_IDLE;
        end
        else if (restart)
        begin
            state_next = SSLI_ST_ON;
            code_next = i_err_code;
            blk_next = 4'h0;
            round_next = 3'h0;
        end
        else if (tk.tick)
        begin
            case (state_reg)
                SSLI_ST_ON:
                begin
                    state_next = SSLI_ST_OFF; // [R13]
                end
                SSLI_ST_OFF:
                begin
                    if (blk_reg + 4'h1 == err_len(code_reg))
                    begin
                        state_next = SSLI_ST_PAUSE; // [R10]
                        pause_next = 3'h0;
                        if (round_reg != `SSLI_BEEP_ROUNDS)
                        begin
                            round_next = round_reg + 3'h1; // [R11]
                        end
                    end
                    else
                    begin
                        state_next = SSLI_ST_ON;
                        blk_next = blk_reg + 4'h1;
                    end
                end
                SSLI_ST_PAUSE:
                begin
                    if (pause_reg == 3'(`SSLI_PAUSE_TICKS - 1))
                    begin
                        state_next = SSLI_ST_ON; // [R10]
                        blk_next = 4'h0;
                    end
                    else
                    begin
                        pause_next = pause_reg + 3'h1;
                    end
                end
                default:
                begin
                    state_next = SSLI_ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Green sleep blinker
    // ------------------------------------------------------------
    ssli_pwr_t pwr_prev_reg;
    logic g_half_reg, g_half_next;
    logic g_on_reg, g_on_next;
    logic [2:0] g_cnt_reg, g_cnt_next;
    logic green_next, red_next, beep_next;

    always_comb
    begin
        g_half_next = g_half_reg;
        g_on_next = g_on_reg;
        g_cnt_next = g_cnt_reg;
        if (i_pwr_state != pwr_prev_reg)
        begin
            g_half_next = 1'b0;
            g_on_next = 1'b1;
            g_cnt_next = 3'h0;
        end
        else if (tk.tick)
        begin
            // Two ticks per phase give the half-hertz rate
            g_half_next = !g_half_reg; // [R2]
            if (g_half_reg)
            begin
                g_on_next = !g_on_reg;
                if (g_on_reg && g_cnt_reg != `SSLI_S4_BLINKS)
                begin
                    g_cnt_next = g_cnt_reg + 3'h1; // [R3]
                end
            end
        end
        case (i_pwr_state)
            SSLI_PWR_S0: green_next = 1'b1; // [R1]
            SSLI_PWR_S1: green_next = g_on_next; // [R2]
            SSLI_PWR_S3: green_next = g_on_next; // [R2]
            SSLI_PWR_S4: green_next = i_sleep_blink_en && g_on_next &&
                (g_cnt_next != `SSLI_S4_BLINKS); // [R3]
            default: green_next = 1'b0; // [R1]
        endcase
        if (state_next != SSLI_ST_IDLE)
        begin
            green_next = 1'b0; // [R13]
        end
        red_next = (state_next == SSLI_ST_ON);
        beep_next = red_next && (round_next != `SSLI_BEEP_ROUNDS); // [R12]
    end

    always_ff @(posedge i_sys_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            state_reg <= SSLI_ST_IDLE;
            code_reg <= 4'h0;
            blk_reg <= 4'h0;
            pause_reg <= 3'h0;
            round_reg <= 3'h0;
            pwr_prev_reg <= SSLI_PWR_S5;
            g_half_reg <= 1'b0;
            g_on_reg <= 1'b0;
            g_cnt_reg <= 3'h0;
            o_led_green <= 1'b0;
            o_led_red <= 1'b0;
            o_beep <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            code_reg <= code_next;
            blk_reg <= blk_next;
            pause_reg <= pause_next;
            round_reg <= round_next;
            pwr_prev_reg <= i_pwr_state;
            g_half_reg <= g_half_next;
            g_on_reg <= g_on_next;
            g_cnt_reg <= g_cnt_next;
            o_led_green <= green_next;
            o_led_red <= red_next;
            o_beep <= beep_next;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [`SSLI_CNT_W-1:0] red_run_reg;
    always_ff @(posedge i_sys_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            red_run_reg <= '0;
        end
        else
        begin
            red_run_reg <= (o_led_red && !restart) ?
                red_run_reg + `SSLI_CNT_W'(1) : '0;
        end
    end
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!rst_n_reg);

    sequence s_quiet;
        !err_valid;
    endsequence
    sequence s_sleep;
        s_quiet ##0 (i_pwr_state == SSLI_PWR_S1 ||
            i_pwr_state == SSLI_PWR_S3);
    endsequence
    sequence s_burst_end;
        state_reg == SSLI_ST_OFF && tk.tick && !restart && err_valid &&
            blk_reg + 4'h1 == err_len(code_reg);
    endsequence
    sequence s_pause_end;
        state_reg == SSLI_ST_PAUSE && tk.tick && !restart && err_valid &&
            pause_reg == 3'(`SSLI_PAUSE_TICKS - 1);
    endsequence
    chk_green_steady: assert property ( // [R1]
        rst_n_reg ##0 s_quiet ##0 i_pwr_state == SSLI_PWR_S0
            |=> o_led_green)
        else $error("green not steady in working state");
    chk_soft_off_dark: assert property ( // [R1]
        s_quiet ##0 i_pwr_state == SSLI_PWR_S5 |=>
            !o_led_green && !o_led_red)
        else $error("LED lit in soft off");
    chk_sleep_blink: assert property ( // [R2]
        s_sleep |=> o_led_green == g_on_reg && !o_beep)
        else $error("sleep green does not follow blinker");
    chk_disk_dark: assert property ( // [R3]
        s_quiet ##0 i_pwr_state == SSLI_PWR_S4 && !i_sleep_blink_en
            |=> !o_led_green)
        else $error("LED lit in suspend to disk");
    chk_burst_count: assert property ( // [R8]
        s_burst_end |=> state_reg == SSLI_ST_PAUSE && !o_led_red)
        else $error("burst did not end after its blink count");
    chk_pause_repeat: assert property ( // [R10]
        s_pause_end |=> o_led_red && blk_reg == 4'h0)
        else $error("burst did not repeat after pause");
    chk_beep_rounds: assert property ( // [R11]
        round_reg == `SSLI_BEEP_ROUNDS |-> !o_beep)
        else $error("beep after fifth burst");
    chk_beep_with_red: assert property ( // [R12]
        o_beep |-> o_led_red && state_reg == SSLI_ST_ON)
        else $error("beep without red blink");
    chk_red_half: assert property ( // [R13]
        o_led_red |-> red_run_reg < `SSLI_CNT_W'(HALF_CYC))
        else $error("red on phase too long");
    chk_err_over_green: assert property ( // [R13]
        state_reg != SSLI_ST_IDLE |-> !o_led_green)
        else $error("green shown during error");
    chk_quiet_no_red: assert property ( // [R4]
        s_quiet |=> !o_led_red && !o_beep)
        else $error("red or beep without error");

endmodule // ssli_top

/* tb/ssli_led_spk_model.sv */
// Power lamp and chassis speaker model that counts what it shows
`timescale 1ns/1ns
module ssli_led_spk_model (
    input wire logic i_clk,
    input wire logic i_red,
    input wire logic i_beep,
    output int o_red_blinks,
    output int o_beeps
);
    logic red_d = 1'b0;
    logic beep_d = 1'b0;
    int red_cnt = 0;
    int beep_cnt = 0;
    assign o_red_blinks = red_cnt;
    assign o_beeps = beep_cnt;
    // Lamp and speaker react to settled levels, away from the clock edge
    always @(negedge i_clk)
    begin
        if (i_red && !red_d) red_cnt <= red_cnt + 1;
        if (i_beep && !beep_d) beep_cnt <= beep_cnt + 1;
        red_d <= i_red;
        beep_d <= i_beep;
    end
endmodule // ssli_led_spk_model

/* tb/test_ssli_top.sv */
// Self-checking bench for the status indicator sequencer
`timescale 1ns/1ns
module test_ssli_top;
    import ssli_pkg::*;
    // Short half period keeps bursts of eleven within a few thousand cycles
    localparam int H = 8;
    logic i_sys_clk = 1'b0;
    logic i_arst_n = 1'b0;
    ssli_pwr_t i_pwr_state = SSLI_PWR_S5;
    logic [3:0] i_err_code = 4'h0;
    logic i_sleep_blink_en = 1'b0;
    logic o_led_green;
    logic o_led_red;
    logic o_beep;
    int num_errors = 0;
    int tests_run = 0;
    int red_blinks;
    int beeps;
    logic [16:0] seed = 17'h11a7c;
    ssli_pwr_t st_tab[5] = '{SSLI_PWR_S0, SSLI_PWR_S1, SSLI_PWR_S3,
        SSLI_PWR_S4, SSLI_PWR_S5};

    always #50 i_sys_clk = ~i_sys_clk;

    ssli_top #(.HALF_CYC(H)) u_ssli_top (
        .i_sys_clk(i_sys_clk),
        .i_arst_n(i_arst_n),
        .i_pwr_state(i_pwr_state),
        .i_err_code(i_err_code),
        .i_sleep_blink_en(i_sleep_blink_en),
        .o_led_green(o_led_green),
        .o_led_red(o_led_red),
        .o_beep(o_beep)
    );

    ssli_led_spk_model u_ssli_led_spk_model (
        .i_clk(i_sys_clk),
        .i_red(o_led_red),
        .i_beep(o_beep),
        .o_red_blinks(red_blinks),
        .o_beeps(beeps)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [16:0] lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction

    task automatic check(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1)
        begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    task automatic summarize();
        $display("checks %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic do_reset(input int n);
        @(negedge i_sys_clk);
        i_arst_n = 1'b0;
        repeat (n) @(negedge i_sys_clk);
        check({o_led_green, o_led_red, o_beep} === 3'h0, "live in reset");
        i_arst_n = 1'b1;
        repeat (4) @(negedge i_sys_clk);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic pwr_run(input ssli_pwr_t st, input logic en,
        input int n);
        int hi;
        int rises;
        int tr;
        int run;
        int bad;
        logic prev;
        hi = 0;
        rises = 0;
        tr = 0;
        run = 0;
        bad = 0;
        prev = o_led_green;
        seed = lfsr(seed);
        // Only ignored codes here: 1 and 12..15, else none
        i_err_code = (seed[3:0] inside {[4'h2:4'hb]}) ? 4'h0 : seed[3:0];
        i_pwr_state = st;
        i_sleep_blink_en = en;
        repeat (2) @(posedge i_sys_clk);
        for (int k = 0; k < n; k++)
        begin
            @(negedge i_sys_clk);
            hi += o_led_green;
            rises += (o_led_green && !prev);
            // First two phases may be short: divider free-runs
            if (o_led_green !== prev)
            begin
                tr++;
                if (tr >= 3) bad += (run != 2 * H);
                run = 0;
            end
            run++;
            prev = o_led_green;
            check(o_led_red === 1'b0 && o_beep === 1'b0 &&
                (o_led_green === 1'b0 || o_led_green === 1'b1),
                "lamp outside error");
        end
        case (st)
            SSLI_PWR_S0: check(hi == n, "steady green");
            SSLI_PWR_S1, SSLI_PWR_S3:
                check(bad == 0 && tr >= 4, "green blink");
            SSLI_PWR_S4: check(rises == (en ? 4 : 0) &&
                o_led_green === 1'b0, "disk sleep blinks");
            default: check(hi == 0, "dark lamp");
        endcase
        $display("test power state %0d done", st);
    endtask

    task automatic err_run(input logic [3:0] c, input int n);
        int per;
        int p;
        int er;
        int eb;
        int r0;
        int b0;
        logic xr;
        logic xb;
        per = (2 * c + 4) * H;
        r0 = red_blinks;
        b0 = beeps;
        er = 0;
        eb = 0;
        seed = lfsr(seed);
        i_pwr_state = st_tab[seed % 5];
        i_sleep_blink_en = seed[5];
        i_err_code = c;
        // Red rises at the first edge; first sample is right after it
        repeat (1) @(posedge i_sys_clk);
        for (int k = 1; k <= n; k++)
        begin
            @(negedge i_sys_clk);
            p = (k - 1) % per;
            xr = p < 2 * c * H && (p / H) % 2 == 0;
            xb = xr && (k - 1) / per < 5;
            er += (xr && p % (2 * H) == 0);
            eb += (xb && p % (2 * H) == 0);
            check(o_led_red === xr && o_beep === xb && o_led_green === 1'b0,
                "error pattern");
        end
        #1;
        check(red_blinks - r0 == er && beeps - b0 == eb,
            "blink or beep count");
        $display("test error code %0d done", c);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        do_reset(8);
        pwr_run(SSLI_PWR_S0, 1'b0, 6 * H);
        pwr_run(SSLI_PWR_S5, 1'b1, 2 * H);
        pwr_run(SSLI_PWR_S1, 1'b0, 12 * H);
        pwr_run(SSLI_PWR_S5, 1'b0, 2 * H);
        pwr_run(SSLI_PWR_S3, 1'b1, 12 * H);
        pwr_run(SSLI_PWR_S5, 1'b0, 2 * H);
        pwr_run(SSLI_PWR_S4, 1'b1, 24 * H);
        pwr_run(SSLI_PWR_S4, 1'b0, 8 * H);
        // Unused state codes 2, 6 and 7 leave the lamp dark
        for (int v = 5; v <= 7; v++)
            pwr_run(ssli_pwr_t'((v == 5) ? 3'h2 : v[2:0]), 1'b1,
                4 * H);
        for (int c = 2; c <= 11; c++)
            err_run(c[3:0], 6 * (2 * c + 4) * H + 2 * H);
        // Code change while idle between blinks restarts burst and beeps
        err_run(4'h4, 4 * H);
        err_run(4'h7, 36 * H);
        i_err_code = 4'h0;
        do_reset(2);
        err_run(4'h2, 16 * H);
        pwr_run(SSLI_PWR_S0, 1'b0, 4 * H);
        summarize();
    end

    initial
    begin
        #(100000 * 100);
        num_errors++;
        $display("CHECK FAILED at %0t: run limit reached", $time);
        summarize();
    end
endmodule // test_ssli_top
